// ---- rtl/core_pkg.sv ----
// Shared constants and types for the 8-bit execution core
`default_nettype none
package core_pkg;

    // Widths and sizes
    localparam int PC_WIDTH    = 10;
    localparam int INSTR_WIDTH = 14;
    localparam int DATA_WIDTH  = 8;
    localparam int FILE_AWIDTH = 7;
    localparam int RAM_DEPTH   = 128;

    // Program counter reach: 512 words small, 1K words large
    localparam logic [9:0] SMALL_PC_MASK = 10'h1ff;
    localparam logic [9:0] LARGE_PC_MASK = 10'h3ff;
    localparam logic [9:0] PC_STEP       = 10'h001;

    // Reset values
    localparam logic [9:0] PC_RESET     = 10'h000;
    localparam logic [7:0] W_RESET      = 8'h00;
    localparam logic [2:0] STATUS_RESET = 3'h0;
    localparam logic [7:0] FSR_RESET    = 8'h00;
    localparam logic [1:0] PCHI_RESET   = 2'h0;

    // Data address map
    localparam logic [6:0] ADDR_INDIRECT = 7'h00;
    localparam logic [6:0] ADDR_PC_LOW   = 7'h02;
    localparam logic [6:0] ADDR_STATUS   = 7'h03;
    localparam logic [6:0] ADDR_POINTER  = 7'h04;
    localparam logic [6:0] ADDR_PC_HIGH  = 7'h0a;
    localparam logic [6:0] RAM_BASE      = 7'h0c;

    // Status bit positions
    localparam int STATUS_C      = 0;
    localparam int STATUS_NIBBLE = 1;
    localparam int STATUS_Z      = 2;

    // Instruction field positions
    localparam int CLASS_MSB = 13;
    localparam int CLASS_LSB = 12;
    localparam int OP_MSB    = 11;
    localparam int OP_LSB    = 8;
    localparam int DEST_BIT  = 7;

    typedef enum logic [1:0] {
        CLASS_FILE,
        CLASS_LITERAL,
        CLASS_JUMP,
        CLASS_SKIP
    } instr_class_type;

    typedef enum logic [3:0] {
        ALU_PASS_B,
        ALU_ADD,
        ALU_SUB,
        ALU_AND,
        ALU_IOR,
        ALU_XOR,
        ALU_COM,
        ALU_INC,
        ALU_DEC,
        ALU_RLF,
        ALU_RRF,
        ALU_SWAP,
        ALU_CLR,
        ALU_PASS_W
    } alu_op_type;

    typedef struct packed {
        instr_class_type cls;
        alu_op_type      op;
        logic            to_file;
        logic [6:0]      file_addr;
        logic [7:0]      literal;
        logic [9:0]      target;
    } decode_type;

    typedef struct packed {
        logic [7:0] value;
        logic       carry;
        logic       nibble_carry_flag;
        logic       zero;
        logic       set_c;
        logic       set_nibble;
        logic       set_z;
    } alu_out_type;

endpackage : core_pkg
`default_nettype wire

// ---- rtl/core_alu.sv ----
// Combinational 8-bit ALU with flag outputs
`default_nettype none
module core_alu (
    input  wire logic [core_pkg::DATA_WIDTH-1:0] acc,
    input  wire logic [core_pkg::DATA_WIDTH-1:0] operand,
    input  wire core_pkg::alu_op_type            op,
    input  wire logic                            carry_in,
    output core_pkg::alu_out_type                result
);
    import core_pkg::*;

    logic [8:0] sum;
    logic [4:0] low;

    // Operation select; subtraction is operand minus accumulator
    always_comb begin
        result = '0;
        sum    = '0;
        low    = '0;
        unique case (op)
            ALU_PASS_B: begin
                result.value = operand;
                result.set_z = 1'b1;
            end
            ALU_PASS_W: begin
                result.value = acc;
            end
            ALU_ADD: begin
                sum = {1'b0, operand} + {1'b0, acc};
                low = {1'b0, operand[3:0]} + {1'b0, acc[3:0]};
                result.value             = sum[7:0];
                result.carry             = sum[8];
                result.nibble_carry_flag = low[4];
                result.set_c      = 1'b1;
                result.set_nibble = 1'b1;
                result.set_z      = 1'b1;
            end
            ALU_SUB: begin
                // Add of the complement: carry out low means a borrow occurred
                sum = {1'b0, operand} + {1'b0, ~acc} + 9'h001;
                low = {1'b0, operand[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
                result.value             = sum[7:0];
                result.carry             = sum[8];
                result.nibble_carry_flag = low[4];
                result.set_c      = 1'b1;
                result.set_nibble = 1'b1;
                result.set_z      = 1'b1;
            end
            ALU_AND: begin
                result.value = operand & acc;
                result.set_z = 1'b1;
            end
            ALU_IOR: begin
                result.value = operand | acc;
                result.set_z = 1'b1;
            end
            ALU_XOR: begin
                result.value = operand ^ acc;
                result.set_z = 1'b1;
            end
            ALU_COM: begin
                result.value = ~operand;
                result.set_z = 1'b1;
            end
            ALU_INC: begin
                result.value = operand + 8'h01;
                result.set_z = 1'b1;
            end
            ALU_DEC: begin
                result.value = operand - 8'h01;
                result.set_z = 1'b1;
            end
            ALU_RLF: begin
                result.value = {operand[6:0], carry_in};
                result.carry = operand[7];
                result.set_c = 1'b1;
            end
            ALU_RRF: begin
                result.value = {carry_in, operand[7:1]};
                result.carry = operand[0];
                result.set_c = 1'b1;
            end
            ALU_SWAP: begin
                result.value = {operand[3:0], operand[7:4]};
            end
            ALU_CLR: begin
                result.set_z = 1'b1;
            end
            default: begin
                result.value = operand;
            end
        endcase
        result.zero = (result.value == 8'h00);
    end

endmodule : core_alu
`default_nettype wire

// ---- rtl/core_file_ram.sv ----
// General purpose data RAM behind the data bus
`default_nettype none
module core_file_ram (
    input  wire logic                             core_clk,
    input  wire logic                             write_en,
    input  wire logic [core_pkg::FILE_AWIDTH-1:0] write_addr,
    input  wire logic [core_pkg::DATA_WIDTH-1:0]  write_data,
    input  wire logic [core_pkg::FILE_AWIDTH-1:0] read_addr,
    output logic      [core_pkg::DATA_WIDTH-1:0]  read_data
);
    import core_pkg::*;

    // Contents are undefined after reset, as in any RAM
    logic [DATA_WIDTH-1:0] mem [RAM_DEPTH];

    // Write port
    always_ff @(posedge core_clk) begin
        if (write_en) begin
            mem[write_addr] <= write_data;
        end
    end

    // Read is combinational so execute finishes in one cycle
    assign read_data = mem[read_addr];

endmodule : core_file_ram
`default_nettype wire

// ---- rtl/core_exec.sv ----
// Fetch/execute core: program bus, pipeline, file map and ALU
`default_nettype none
module core_exec #(
    parameter bit LARGE_VARIANT = 1'b1
) (
    input  wire logic                             core_clk,
    input  wire logic                             rst,
    output logic      [core_pkg::PC_WIDTH-1:0]    prog_addr,
    input  wire logic [core_pkg::INSTR_WIDTH-1:0] prog_data,
    output logic      [core_pkg::DATA_WIDTH-1:0]  acc_value,
    output logic      [core_pkg::DATA_WIDTH-1:0]  status_value,
    output logic                                  retire,
    output logic                                  flush
);
    import core_pkg::*;

    // Architectural and pipeline state
    logic [PC_WIDTH-1:0]    pc;
    logic [INSTR_WIDTH-1:0] ir;
    logic                   ir_valid;
    logic [DATA_WIDTH-1:0]  w;
    logic [2:0]             status;
    logic [DATA_WIDTH-1:0]  fsr;
    logic [1:0]             pclath;
    logic                   flushed;

    logic [PC_WIDTH-1:0]    next_pc;
    logic [INSTR_WIDTH-1:0] next_ir;
    logic                   next_ir_valid;
    logic [DATA_WIDTH-1:0]  next_w;
    logic [2:0]             next_status;
    logic [DATA_WIDTH-1:0]  next_fsr;
    logic [1:0]             next_pclath;
    logic                   next_flushed;

    // Datapath nets
    decode_type             dec;
    logic [FILE_AWIDTH-1:0] eff_addr;
    logic [DATA_WIDTH-1:0]  ram_rdata;
    logic [DATA_WIDTH-1:0]  file_value;
    logic [DATA_WIDTH-1:0]  operand;
    alu_out_type            alu;
    logic                   ram_we;
    logic                   dest_file;
    logic [PC_WIDTH-1:0]    pc_mask;

    // Split an instruction word into its fields
    function automatic decode_type decode_instr(input logic [INSTR_WIDTH-1:0] word);
        decode_type d;
        d.cls       = instr_class_type'(word[CLASS_MSB:CLASS_LSB]);
        d.op        = alu_op_type'(word[OP_MSB:OP_LSB]);
        d.to_file   = word[DEST_BIT];
        d.file_addr = word[FILE_AWIDTH-1:0];
        d.literal   = word[DATA_WIDTH-1:0];
        d.target    = word[PC_WIDTH-1:0];
        return d;
    endfunction : decode_instr

    // Ops that take one operand; with a literal they act on the accumulator
    function automatic logic is_unary(input alu_op_type op);
        return (op == ALU_COM) || (op == ALU_INC) || (op == ALU_DEC) ||
               (op == ALU_RLF) || (op == ALU_RRF) || (op == ALU_SWAP) ||
               (op == ALU_CLR);
    endfunction : is_unary

    // Keep counter inside the fitted program store
    assign pc_mask = LARGE_VARIANT ? LARGE_PC_MASK : SMALL_PC_MASK;

    // Program bus: address straight from the counter register
    assign prog_addr = pc;

    assign dec = decode_instr(ir);

    // Address slot zero reaches the file that the pointer names
    assign eff_addr = (dec.file_addr == ADDR_INDIRECT) ?
                      fsr[FILE_AWIDTH-1:0] : dec.file_addr;

    // Data bus: RAM lives apart from program storage
    core_file_ram u_ram (
        .core_clk   (core_clk),
        .write_en   (ram_we),
        .write_addr (eff_addr),
        .write_data (alu.value),
        .read_addr  (eff_addr),
        .read_data  (ram_rdata)
    );

    // File read mux; accumulator has no slot here
    always_comb begin
        file_value = 8'h00;
        unique case (eff_addr)
            ADDR_INDIRECT: file_value = 8'h00; // Pointer to itself reads zero
            ADDR_PC_LOW:   file_value = pc[7:0];
            ADDR_STATUS:   file_value = {5'h00, status};
            ADDR_POINTER:  file_value = fsr;
            ADDR_PC_HIGH:  file_value = {6'h00, pclath};
            default: begin
                if (eff_addr >= RAM_BASE) begin
                    file_value = ram_rdata;
                end
            end
        endcase
    end

    // Second operand: literal, accumulator or file register
    always_comb begin
        operand = file_value;
        if (dec.cls == CLASS_LITERAL) begin
            if (is_unary(dec.op)) begin
                operand = w;
            end else begin
                operand = dec.literal;
            end
        end
    end

    core_alu u_alu (
        .acc      (w),
        .operand  (operand),
        .op       (dec.op),
        .carry_in (status[STATUS_C]),
        .result   (alu)
    );

    assign dest_file = (dec.cls != CLASS_LITERAL) && dec.to_file;

    // Next state of pipeline, counter, accumulator and special registers
    always_comb begin
        // Fetch always runs beside execute
        next_pc       = (pc + PC_STEP) & pc_mask;
        next_ir       = prog_data;
        next_ir_valid = 1'b1;
        next_flushed  = 1'b0;
        next_w        = w;
        next_status   = status;
        next_fsr      = fsr;
        next_pclath   = pclath;
        ram_we        = 1'b0;
        if (ir_valid) begin
            if (dec.cls == CLASS_JUMP) begin
                // Prefetched word is dropped: jump costs two cycles
                next_pc       = dec.target & pc_mask;
                next_ir_valid = 1'b0;
                next_flushed  = 1'b1;
            end else begin
                if (dest_file) begin
                    unique case (eff_addr)
                        ADDR_PC_LOW: begin
                            // Computed jump also discards the prefetch
                            next_pc = {pclath, alu.value} & pc_mask;
                            next_ir_valid = 1'b0;
                            next_flushed  = 1'b1;
                        end
                        ADDR_STATUS:  next_status = alu.value[2:0];
                        ADDR_POINTER: next_fsr    = alu.value;
                        ADDR_PC_HIGH: next_pclath = alu.value[1:0];
                        default:      ram_we = (eff_addr >= RAM_BASE);
                    endcase
                end else begin
                    next_w = alu.value;
                end
                // Flag updates win over a plain write to status
                if (alu.set_c) begin
                    next_status[STATUS_C] = alu.carry;
                end
                if (alu.set_nibble) begin
                    next_status[STATUS_NIBBLE] = alu.nibble_carry_flag;
                end
                if (alu.set_z) begin
                    next_status[STATUS_Z] = alu.zero;
                end
                // Skip on zero result: next word is dropped
                if ((dec.cls == CLASS_SKIP) && alu.zero) begin
                    next_ir_valid = 1'b0;
                    next_flushed  = 1'b1;
                end
            end
        end
    end

    // Registers only; first slot after reset holds no instruction
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pc       <= PC_RESET;
            ir       <= '0;
            ir_valid <= 1'b0;
            w        <= W_RESET;
            status   <= STATUS_RESET;
            fsr      <= FSR_RESET;
            pclath   <= PCHI_RESET;
            flushed  <= 1'b0;
        end else begin
            pc       <= next_pc;
            ir       <= next_ir;
            ir_valid <= next_ir_valid;
            w        <= next_w;
            status   <= next_status;
            fsr      <= next_fsr;
            pclath   <= next_pclath;
            flushed  <= next_flushed;
        end
    end

    // Observation outputs, all from flops
    assign acc_value    = w;
    assign status_value = {5'h00, status};
    assign retire       = ir_valid;
    assign flush        = flushed;

endmodule : core_exec
`default_nettype wire

// ---- bench/core_exec_props.sv ----
// Port-level checker for the fetch/execute core
`default_nettype none
module core_exec_props
    import core_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
) (
    input wire logic                             core_clk,
    input wire logic                             rst,
    input wire logic [core_pkg::PC_WIDTH-1:0]    prog_addr,
    input wire logic [core_pkg::INSTR_WIDTH-1:0] prog_data,
    input wire logic [core_pkg::DATA_WIDTH-1:0]  acc_value,
    input wire logic [core_pkg::DATA_WIDTH-1:0]  status_value,
    input wire logic                             retire,
    input wire logic                             flush
);
    logic [13:0] exec_word;
    logic [9:0]  mask;
    logic [9:0]  tgt;
    logic [3:0]  op;
    logic [7:0]  lit;
    logic        is_lit;
    logic        plain;
    logic [8:0]  add_sum;
    logic        add_nib;
    logic        sub_c;
    logic        sub_nib;

    // Mirror of the word in execute, since the ports do not show it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            exec_word <= '0;
        end else begin
            exec_word <= prog_data;
        end
    end

    // Decode and reference arithmetic for literal work
    always_comb begin
        mask    = LARGE_VARIANT ? LARGE_PC_MASK : SMALL_PC_MASK;
        tgt     = exec_word[9:0] & mask;
        op      = exec_word[11:8];
        lit     = exec_word[7:0];
        is_lit  = exec_word[13:12] == CLASS_LITERAL;
        plain   = is_lit || (exec_word[13:12] == CLASS_FILE
                  && !(exec_word[7] && exec_word[6:0] == ADDR_PC_LOW));
        add_sum = {1'b0, lit} + {1'b0, acc_value};
        add_nib = ({1'b0, lit[3:0]} + {1'b0, acc_value[3:0]}) > 5'h0f;
        sub_c   = lit >= acc_value;
        sub_nib = lit[3:0] >= acc_value[3:0];
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    AST_RESET_CLEAN: assert property (
        $fell(rst) |-> prog_addr == PC_RESET && acc_value == W_RESET && !retire && !flush)
        else $error("outputs not at reset values after release");
    AST_FETCH_NEXT: assert property (
        retire && plain |=> prog_addr == (($past(prog_addr) + PC_STEP) & mask))
        else $error("fetch address did not step by one");
    AST_ONE_CYCLE: assert property (
        retire && plain |=> retire && !flush)
        else $error("plain instruction did not finish in one cycle");
    AST_BRANCH_TWO: assert property (
        retire && exec_word[13:12] == CLASS_JUMP |=> !retire && flush
            && prog_addr == $past(tgt) ##1 retire)
        else $error("jump did not take exactly two cycles");
    AST_FLUSH_SLOT: assert property (
        $rose(flush) |-> !retire ##1 retire && !flush)
        else $error("discarded slot not a single cycle");
    AST_PC_REACH: assert property (
        (prog_addr & ~mask) == 10'h000)
        else $error("program address beyond variant reach");
    AST_AND_RESULT: assert property (
        retire && is_lit && op == ALU_AND |=> acc_value == ($past(lit) & $past(acc_value))
            && status_value[7:3] == 5'h00)
        else $error("literal and result wrong");
    AST_PASS_ZERO: assert property (
        retire && is_lit && op == ALU_PASS_B |=> acc_value == $past(lit)
            && status_value[STATUS_Z] == ($past(lit) == 8'h00))
        else $error("literal load or zero flag wrong");
    AST_ADD_FLAGS: assert property (
        retire && is_lit && op == ALU_ADD |=> {status_value[STATUS_C], acc_value}
            == $past(add_sum) && status_value[STATUS_NIBBLE] == $past(add_nib))
        else $error("add result or carries wrong");
    AST_SUB_BORROW: assert property (
        retire && is_lit && op == ALU_SUB |=> status_value[STATUS_C] == $past(sub_c)
            && status_value[STATUS_NIBBLE] == $past(sub_nib))
        else $error("subtract borrow flags wrong");

    COV_JUMP: cover property (retire && exec_word[13:12] == CLASS_JUMP);
    COV_SKIP: cover property (retire && exec_word[13:12] == CLASS_SKIP ##1 flush);
    COV_BORROW: cover property (retire && is_lit && op == ALU_SUB && !sub_c);
endmodule : core_exec_props

bind core_exec core_exec_props #(.LARGE_VARIANT(LARGE_VARIANT)) u_props (
    .core_clk(core_clk), .rst(rst), .prog_addr(prog_addr), .prog_data(prog_data),
    .acc_value(acc_value), .status_value(status_value), .retire(retire), .flush(flush));
`default_nettype wire

// ---- bench/risc_core_alu_datapath_bench.sv ----
// Self-checking bench for the fetch/execute core
`default_nettype none
module risc_core_alu_datapath_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [9:0] pc; logic [7:0] w; logic [2:0] st;} note_type;
    localparam logic [13:0] HARM = 14'h1c00; // Clears W if a dropped slot ever ran
    logic        core_clk;
    logic        rst = 1'b1;
    logic [9:0]  prog_addr;
    logic [9:0]  small_addr;
    logic [13:0] prog_data;
    logic [13:0] small_data;
    logic [7:0]  acc_value;
    logic [7:0]  status_value;
    logic        retire;
    logic        flush;
    logic [13:0] rom [0:1023] = '{default: 14'h0000};
    logic [7:0]  fmem [0:127];
    note_type    notes[$];
    note_type    cur;
    logic        have = 1'b0;
    logic [9:0]  a;
    logic [7:0]  ew;
    logic [2:0]  est;
    logic [7:0]  k;
    int          n_mismatch = 0;
    int          checks = 0;
    int          cycles = 0;

    // Program store reads combinationally, as the core expects
    assign prog_data  = rom[prog_addr];
    assign small_data = rom[small_addr];

    core_exec #(.LARGE_VARIANT(1'b1)) DUT (.core_clk(core_clk), .rst(rst),
        .prog_addr(prog_addr), .prog_data(prog_data), .acc_value(acc_value),
        .status_value(status_value), .retire(retire), .flush(flush));
    core_exec #(.LARGE_VARIANT(1'b0)) small_dut (.core_clk(core_clk), .rst(rst),
        .prog_addr(small_addr), .prog_data(small_data), .acc_value(), .status_value(),
        .retire(), .flush());

    // Clock generation
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic cmp_addr(input logic [9:0] got, input logic [9:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t address got %h expected %h", $time, got, exp);
        end
    endtask : cmp_addr

    task automatic cmp_data(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t data got %h expected %h", $time, got, exp);
        end
    endtask : cmp_data

    // Reference ALU: returns {result, zero, nibble carry, carry}
    function automatic logic [10:0] model(input logic [3:0] op, input logic [7:0] b,
                                          input logic [7:0] w, input logic [2:0] st);
        logic [7:0] r;
        logic [2:0] f;
        r = b;
        f = st;
        case (op)
            4'h1: begin
                {f[0], r} = {1'b0, b} + {1'b0, w};
                f[1] = ({1'b0, b[3:0]} + {1'b0, w[3:0]}) > 5'h0f;
            end
            4'h2: begin
                r = b - w;
                f[0] = b >= w;
                f[1] = b[3:0] >= w[3:0];
            end
            4'h3: r = b & w;
            4'h4: r = b | w;
            4'h5: r = b ^ w;
            4'h6: r = ~b;
            4'h7: r = b + 8'h01;
            4'h8: r = b - 8'h01;
            4'h9: {f[0], r} = {b, st[0]};
            4'ha: {r, f[0]} = {st[0], b};
            4'hb: r = {b[3:0], b[7:4]};
            4'hc: r = 8'h00;
            4'hd: r = w;
            default: r = b;
        endcase
        if (op <= 4'h8 || op == 4'hc) f[2] = r == 8'h00;
        return {r, f};
    endfunction : model

    // Places a word in the store and notes what it must leave behind
    task automatic emit(input logic [13:0] word);
        logic [1:0]  cls;
        logic [3:0]  op;
        logic [7:0]  b;
        logic [10:0] m;
        logic [9:0]  nxt;
        cls = word[13:12];
        op = word[11:8];
        rom[a] = word;
        nxt = a + 10'h001;
        if (cls == 2'd2) begin
            nxt = word[9:0];
        end else begin
            if (cls == 2'd1) b = (op >= 4'h6 && op <= 4'hc) ? ew : word[7:0];
            else if (word[6:0] == 7'h02) b = nxt[7:0];
            else if (word[6:0] == 7'h03) b = {5'h00, est};
            else b = fmem[word[6:0]];
            m = model(op, b, ew, est);
            est = m[2:0];
            if (cls == 2'd1 || !word[7]) ew = m[10:3];
            else if (word[6:0] == 7'h02) nxt = {2'b00, m[10:3]};
            else fmem[word[6:0]] = m[10:3];
            if (cls == 2'd3 && m[10:3] == 8'h00) begin
                rom[nxt] = HARM;
                nxt = nxt + 10'h001;
            end
        end
        notes.push_back(note_type'{a, ew, est});
        if (nxt != a + 10'h001 && cls != 2'd3) rom[a + 10'h001] = HARM;
        a = nxt;
    endtask : emit

    // Reset held 12 cycles while the store is rebuilt
    task automatic start_phase();
        @(posedge core_clk);
        rst <= 1'b1;
        @(negedge core_clk);
        for (int i = 0; i < 1024; i++) rom[i] = 14'h0000;
        for (int i = 0; i < 128; i++) fmem[i] = 8'h00;
        notes.delete();
        a = 10'h000;
        ew = 8'h00;
        est = 3'h0;
        repeat (11) @(negedge core_clk);
    endtask : start_phase

    task automatic run_phase(input string name);
        @(posedge core_clk);
        rst <= 1'b0;
        repeat (300) begin
            @(negedge core_clk);
            if (notes.size() == 0 && !have) break;
        end
        if (notes.size() != 0) n_mismatch++;
        $display("test %s ended, %0d results left", name, notes.size());
    endtask : run_phase

    // Watcher: fetch address at retire, then W and status one cycle later
    always @(negedge core_clk) begin
        if (rst !== 1'b0) begin
            have = 1'b0;
        end else begin
            if (have) begin
                cmp_data(acc_value, cur.w);
                cmp_data(status_value, {5'h00, cur.st});
                have = 1'b0;
            end
            if (retire === 1'b1 && notes.size() > 0) begin
                cur = notes.pop_front();
                cmp_addr(prog_addr, cur.pc + 10'h001);
                cmp_addr(small_addr, (cur.pc + 10'h001) & 10'h1ff);
                have = 1'b1;
            end
        end
    end

    // Hang guard, well above the three short programs
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            end_sim();
        end
    end

    initial begin
        void'($urandom(32'h1965));
        start_phase();
        for (int i = 0; i < 14; i++) emit({2'b01, 4'(i), 8'($urandom)});
        emit(14'h105a);
        emit(14'h125a);
        emit(14'h1080);
        emit(14'h1210);
        emit(14'h10ff);
        emit(14'h1101);
        emit(14'h100f);
        emit(14'h1101);
        run_phase("literal alu ops");
        start_phase();
        k = 8'($urandom) | 8'h01;
        emit({6'h10, k});
        emit(14'h0da0);
        emit(14'h1c00);
        emit(14'h0120);
        emit(14'h06a0);
        emit(14'h0020);
        emit(14'h0003);
        emit(14'h0002);
        emit(14'h0920);
        run_phase("file register ops");
        start_phase();
        emit(14'h1030);
        emit(14'h0d82);
        emit(14'h3c20);
        emit(14'h3003);
        emit(14'h23fe);
        emit(14'h1101);
        emit(14'h1201);
        run_phase("program flow");
        end_sim();
    end
endmodule : risc_core_alu_datapath_bench
`default_nettype wire
